/* File: fba_top.sv */
// Flash boot selection, table read protection and program/erase engine.
// =====================================================================
// Overview of operation
// - Any single byte can be erased and programmed on its own.
// - Table reads return data only from sectors that are not secured.
// - No read-back verify; a 32-bit CRC covers one sector or all code.
// - Erase and program are blocked while the flash brownout detector trips.
// - The factory serial loader lives in the top 512 bytes of code space.
// - Erase and program are also reachable through four registers.
// - With boot status zero, execution starts at 0000H.
// - Otherwise start address is boot vector high byte, low byte 00H; a boot vector of FFH uses the factory vector.
// - Factory vector is 0FH for four sectors, 1FH for eight sectors.
// - Forcing serial programming mode at power-on acts like nonzero status.
// - In-circuit programming uses a serial clock and serial data pair.
// - Configuration bytes are read at power-up and then stay fixed.
// - One security byte per sector governs that sector's protection.
// - A 64-byte page buffer programs 1 to 64 bytes of a page at once.
// - Each program or erase finishes within 2 ms with on-chip timing.
`timescale 1ns/1ps
`include "fba_defines.svh"
module fba_top
   import fba_pkg::*;
#(
   parameter int NUM_SECTORS = 8,
   parameter int OP_CYCLES = `FBA_OP_CYCLES
) (
   input wire logic clk_i, // Processor clock.
   input wire logic rstn_i, // Asynchronous reset, active low.
   input wire logic [7:0] boot_status_i, // Stored boot status byte.
   input wire logic [7:0] boot_vector_i, // Stored boot vector.
   input wire logic [7:0] user_config_byte_one_i, // First configuration byte.
   input wire logic [7:0] user_config_byte_two_i, // Second configuration byte.
   input wire logic [NUM_SECTORS*8-1:0] sector_sec_i, // Security bytes, sector 0 low.
   input wire logic isp_force_i, // Pin forcing the serial loader.
   input wire logic brownout_detector_i, // Flash supply low, high active.
   output logic [15:0] start_addr_o, // Execution start address.
   output logic start_valid_o, // Start address is settled.
   output logic [15:0] loader_base_o, // Base of the loader region.
   output logic [7:0] cfg_one_o, // Latched first config byte.
   output logic [7:0] cfg_two_o, // Latched second config byte.
   input wire logic tr_req_i, // Table read request.
   input wire logic [15:0] tr_addr_i, // Table read address.
   output logic tr_ready_o, // Table read can be taken.
   output logic [7:0] tr_data_o, // Table read data.
   output logic tr_valid_o, // Table read data valid pulse.
   output logic tr_refused_o, // Table read refused pulse.
   input wire logic iap_wr_i, // Register write strobe.
   input wire logic [1:0] iap_sel_i, // Register select.
   input wire logic [7:0] iap_wdata_i, // Register write data.
   output logic [7:0] iap_rdata_o, // Selected register value.
   output logic [31:0] crc_o, // CRC result.
   input wire logic icp_mode_i, // In-circuit programming active.
   input wire logic icp_sclk_i, // Serial clock from programmer.
   input wire logic icp_sdata_i, // Serial data line, in.
   output logic icp_sdata_o, // Serial data line, out.
   output logic icp_sdata_oe_o, // Serial data line, drive enable.
   output logic [15:0] flash_addr_o, // Array address.
   input wire logic [7:0] flash_rdata_i, // Array read data, same cycle.
   output logic [7:0] flash_wdata_o, // Byte into the array latch.
   output logic flash_we_o, // Byte latch strobe.
   output logic flash_prog_o, // Program pulse, level.
   output logic flash_erase_o, // Erase pulse, level.
   output logic [1:0] flash_esize_o // Erase extent.
);
   localparam int SW = $clog2(NUM_SECTORS);
   localparam int CODE_BYTES = NUM_SECTORS * `FBA_SECTOR_BYTES;
   localparam int HV_CYCLES = OP_CYCLES - `FBA_PAGE_BYTES - 4;
   localparam logic [15:0] LAST_ADDR = 16'(CODE_BYTES - 1);
   localparam logic [7:0] FACTORY_VEC = (NUM_SECTORS == 8) ? `FBA_VEC_EIGHT : `FBA_VEC_FOUR;

   initial begin
      if (NUM_SECTORS != 4 && NUM_SECTORS != 8) begin
         $error("fba_top supports four or eight sectors only");
      end
      if (OP_CYCLES < `FBA_PAGE_BYTES + 8) begin
         $error("fba_top needs a longer operation time");
      end
   end

   // =====================================================================
   // Pin synchronisation
   logic [4:0] pin_sync;
   logic bo_s;
   logic isp_s;
   logic icpm_s;
   logic sclk_s;
   logic sdat_s;

   fba_sync2 #(.W(5)) u_sync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .d_i({brownout_detector_i, isp_force_i, icp_mode_i, icp_sclk_i, icp_sdata_i}),
      .q_o(pin_sync)
   );
   assign {bo_s, isp_s, icpm_s, sclk_s, sdat_s} = pin_sync;

   // =====================================================================
   // Sector protection
   logic [NUM_SECTORS-1:0] sec_rd;
   for (genvar g = 0; g < NUM_SECTORS; g++) begin : g_sec
      assign sec_rd[g] = sector_sec_i[g*8 + `FBA_SEC_READ_BIT];
   end

   fba_top_state_t r_reg;
   fba_top_state_t r_next;

   logic [31:0] crc_step;
   fba_crc_step u_crc (
      .crc_i(r_reg.crc),
      .data_i(flash_rdata_i),
      .crc_o(crc_step)
   );

   // =====================================================================
   // Serial frame decode and register write merge
   logic sclk_rise;
   logic icp_done;
   logic icp_wr;
   logic reg_wr;
   logic [1:0] reg_sel;
   logic [7:0] reg_wdata;
   logic tr_ok;

   assign sclk_rise = icpm_s & sclk_s & ~r_reg.sclk_prev;
   assign icp_done = sclk_rise && (r_reg.icp_cnt == `FBA_ICP_FRAME_BITS - 5'h01);
   assign icp_wr = icp_done & r_reg.icp_hdr[`FBA_ICP_WR_BIT];
   assign reg_wr = icpm_s ? icp_wr : iap_wr_i;
   assign reg_sel = icpm_s ? r_reg.icp_hdr[1:0] : iap_sel_i;
   assign reg_wdata = icpm_s ? {r_reg.icp_in[6:0], sdat_s} : iap_wdata_i;
   assign tr_ready_o = (r_reg.st == FBA_IDLE) & ~reg_wr;
   assign tr_ok = (tr_addr_i <= LAST_ADDR) && !sec_rd[tr_addr_i[`FBA_SECTOR_LSB +: SW]];

   function automatic logic [7:0] reg_value(input fba_top_state_t s, input logic [1:0] sel);
      logic [7:0] v;
      v = '0;
      unique case (sel)
         `FBA_REG_CTRL: begin
            v[`FBA_STAT_BUSY] = (s.st != FBA_IDLE);
            v[`FBA_STAT_FAIL] = s.fail;
            v[`FBA_STAT_CRC_DONE] = s.crc_done;
            v[2:0] = s.cmd;
         end
         `FBA_REG_DATA: v = s.data;
         `FBA_REG_ADDRL: v = s.addr[7:0];
         `FBA_REG_ADDRH: v = s.addr[15:8];
      endcase
      return v;
   endfunction

   // =====================================================================
   // Next state
   always_comb begin
      r_next = r_reg;
      r_next.fwe = 1'b0;
      r_next.tr_valid = 1'b0;
      r_next.tr_refused = 1'b0;
      r_next.sclk_prev = sclk_s;

      if (!icpm_s) begin
         r_next.icp_cnt = '0;
      end else if (sclk_rise) begin
         r_next.icp_in = {r_reg.icp_in[6:0], sdat_s};
         r_next.icp_cnt = icp_done ? 5'h00 : r_reg.icp_cnt + 5'h01;
         r_next.icp_out = {r_reg.icp_out[6:0], 1'b0};
         if (r_reg.icp_cnt == `FBA_ICP_HDR_BITS - 5'h01) begin
            r_next.icp_hdr = {r_reg.icp_in[6:0], sdat_s};
            r_next.icp_out = reg_value(r_reg, {r_reg.icp_in[0], sdat_s});
         end
      end

      // Data and address writes are ignored while an operation runs.
      if (reg_wr && r_reg.st == FBA_IDLE) begin
         unique case (reg_sel)
            `FBA_REG_CTRL: begin
               r_next.cmd = reg_wdata[2:0];
               if (reg_wdata[`FBA_STAT_FAIL]) begin
                  r_next.fail = 1'b0;
               end
               if (reg_wdata[`FBA_STAT_CRC_DONE]) begin
                  r_next.crc_done = 1'b0;
               end
            end
            `FBA_REG_DATA: r_next.data = reg_wdata;
            `FBA_REG_ADDRL: r_next.addr[7:0] = reg_wdata;
            `FBA_REG_ADDRH: r_next.addr[15:8] = reg_wdata;
         endcase
      end

      unique case (r_reg.st)
         FBA_BOOT: begin
            r_next.boot_cnt = r_reg.boot_cnt + 3'h1;
            if (r_reg.boot_cnt == `FBA_BOOT_WAIT) begin
               r_next.st = FBA_IDLE;
               r_next.start_valid = 1'b1;
               r_next.cfg1 = user_config_byte_one_i;
               r_next.cfg2 = user_config_byte_two_i;
               r_next.start_addr = `FBA_START_ZERO;
               if (boot_status_i != `FBA_STATUS_ZERO || isp_s) begin
                  r_next.start_addr = {boot_vector_i, `FBA_LOW_BYTE};
                  if (boot_vector_i == `FBA_ERASED_BYTE) begin
                     r_next.start_addr = {FACTORY_VEC, `FBA_LOW_BYTE};
                  end
               end
            end
         end
         FBA_IDLE: begin
            if (reg_wr && reg_sel == `FBA_REG_CTRL) begin
               unique case (reg_wdata[2:0])
                  `FBA_CMD_LOAD: begin
                     r_next.page[r_reg.addr[5:0]] = r_reg.data;
                     r_next.mask[r_reg.addr[5:0]] = 1'b1;
                  end
                  `FBA_CMD_PROG, `FBA_CMD_ERASE_BYTE, `FBA_CMD_ERASE_PAGE,
                  `FBA_CMD_ERASE_SECTOR: begin
                     if (bo_s) begin
                        r_next.fail = 1'b1;
                     end else if (reg_wdata[2:0] == `FBA_CMD_PROG) begin
                        r_next.idx = '0;
                        r_next.st = FBA_LOAD;
                     end else begin
                        r_next.faddr = r_reg.addr;
                        r_next.esize = (reg_wdata[2:0] == `FBA_CMD_ERASE_BYTE) ?
                           `FBA_ESIZE_BYTE : (reg_wdata[2:0] == `FBA_CMD_ERASE_PAGE) ?
                           `FBA_ESIZE_PAGE : `FBA_ESIZE_SECTOR;
                        r_next.ferase = 1'b1;
                        r_next.timer = '0;
                        r_next.st = FBA_HV;
                     end
                  end
                  `FBA_CMD_CRC_SECTOR, `FBA_CMD_CRC_ALL: begin
                     r_next.crc = `FBA_CRC_INIT;
                     r_next.crc_done = 1'b0;
                     r_next.st = FBA_CRC;
                     if (reg_wdata[2:0] == `FBA_CMD_CRC_ALL) begin
                        r_next.faddr = `FBA_START_ZERO;
                        r_next.crc_end = LAST_ADDR;
                     end else begin
                        r_next.faddr = {r_reg.addr[15:10], 10'h000};
                        r_next.crc_end = {r_reg.addr[15:10], 10'h3FF};
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (tr_req_i) begin
               if (tr_ok) begin
                  r_next.faddr = tr_addr_i;
                  r_next.st = FBA_TREAD;
               end else begin
                  r_next.tr_refused = 1'b1;
               end
            end
         end
         FBA_TREAD: begin
            r_next.tr_data = flash_rdata_i;
            r_next.tr_valid = 1'b1;
            r_next.st = FBA_IDLE;
         end
         FBA_LOAD: begin
            r_next.faddr = {r_reg.addr[15:6], r_reg.idx};
            r_next.fwdata = r_reg.page[r_reg.idx];
            r_next.fwe = r_reg.mask[r_reg.idx];
            r_next.idx = r_reg.idx + 6'h01;
            if (r_reg.idx == 6'(`FBA_PAGE_BYTES - 1)) begin
               r_next.fprog = 1'b1;
               r_next.timer = '0;
               r_next.st = FBA_HV;
            end
         end
         FBA_HV: begin
            r_next.timer = r_reg.timer + 32'h0000_0001;
            if (bo_s || r_reg.timer == 32'(HV_CYCLES - 1)) begin
               r_next.fail = r_reg.fail | bo_s;
               r_next.fprog = 1'b0;
               r_next.ferase = 1'b0;
               r_next.st = FBA_IDLE;
               if (r_reg.fprog) begin
                  r_next.mask = '0;
               end
            end
         end
         FBA_CRC: begin
            r_next.crc = crc_step;
            r_next.faddr = r_reg.faddr + 16'h0001;
            if (r_reg.faddr == r_reg.crc_end) begin
               r_next.crc_done = 1'b1;
               r_next.st = FBA_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r_reg <= '0;
         r_reg.st <= FBA_BOOT;
         r_reg.crc <= `FBA_CRC_INIT;
      end else begin
         r_reg <= r_next;
      end
   end

   // =====================================================================
   // Outputs
   assign start_addr_o = r_reg.start_addr;
   assign start_valid_o = r_reg.start_valid;
   assign loader_base_o = 16'(CODE_BYTES - `FBA_LOADER_BYTES);
   assign cfg_one_o = r_reg.cfg1;
   assign cfg_two_o = r_reg.cfg2;
   assign tr_data_o = r_reg.tr_data;
   assign tr_valid_o = r_reg.tr_valid;
   assign tr_refused_o = r_reg.tr_refused;
   assign iap_rdata_o = reg_value(r_reg, iap_sel_i);
   assign crc_o = r_reg.crc;
   assign icp_sdata_o = r_reg.icp_out[7];
   assign icp_sdata_oe_o = icpm_s && (r_reg.icp_cnt >= `FBA_ICP_HDR_BITS) &&
                           !r_reg.icp_hdr[`FBA_ICP_WR_BIT];
   assign flash_addr_o = r_reg.faddr;
   assign flash_wdata_o = r_reg.fwdata;
   assign flash_we_o = r_reg.fwe;
   assign flash_prog_o = r_reg.fprog;
   assign flash_erase_o = r_reg.ferase;
   assign flash_esize_o = r_reg.esize;
endmodule

/* File: fba_defines.svh */
// Constants for the flash boot and program access block.
`ifndef FBA_DEFINES_SVH
`define FBA_DEFINES_SVH

// =====================================================================
// Timing
`define FBA_CLK_MHZ 125
`define FBA_OP_TIME_US 2000
`define FBA_OP_CYCLES (`FBA_OP_TIME_US * `FBA_CLK_MHZ)
`define FBA_BOOT_WAIT 3'h3

// =====================================================================
// Array geometry
`define FBA_SECTOR_BYTES 1024
`define FBA_SECTOR_LSB 10
`define FBA_PAGE_BYTES 64
`define FBA_PAGE_LSB 6
`define FBA_LOADER_BYTES 512
`define FBA_SEC_READ_BIT 0
`define FBA_ERASED_BYTE 8'hFF

// =====================================================================
// Boot
`define FBA_START_ZERO 16'h0000
`define FBA_LOW_BYTE 8'h00
`define FBA_STATUS_ZERO 8'h00
`define FBA_VEC_FOUR 8'h0F
`define FBA_VEC_EIGHT 8'h1F

// =====================================================================
// Register selects, commands and status bits
`define FBA_REG_CTRL 2'h0
`define FBA_REG_DATA 2'h1
`define FBA_REG_ADDRL 2'h2
`define FBA_REG_ADDRH 2'h3
`define FBA_CMD_NONE 3'h0
`define FBA_CMD_LOAD 3'h1
`define FBA_CMD_PROG 3'h2
`define FBA_CMD_ERASE_BYTE 3'h3
`define FBA_CMD_ERASE_PAGE 3'h4
`define FBA_CMD_ERASE_SECTOR 3'h5
`define FBA_CMD_CRC_SECTOR 3'h6
`define FBA_CMD_CRC_ALL 3'h7
`define FBA_STAT_BUSY 7
`define FBA_STAT_FAIL 6
`define FBA_STAT_CRC_DONE 5
`define FBA_ESIZE_BYTE 2'h0
`define FBA_ESIZE_PAGE 2'h1
`define FBA_ESIZE_SECTOR 2'h2

// =====================================================================
// CRC and serial frame
`define FBA_CRC_INIT 32'hFFFF_FFFF
`define FBA_CRC_POLY 32'hEDB8_8320
`define FBA_ICP_HDR_BITS 5'h08
`define FBA_ICP_FRAME_BITS 5'h10
`define FBA_ICP_WR_BIT 7

`endif

/* File: fba_pkg.sv */
// Types shared by the flash boot and program access block.
package fba_pkg;

   typedef enum logic [2:0] {
      FBA_BOOT,
      FBA_IDLE,
      FBA_TREAD,
      FBA_LOAD,
      FBA_HV,
      FBA_CRC
   } fba_state_t;

   typedef struct packed {
      fba_state_t st;
      logic [2:0] boot_cnt;
      logic [15:0] start_addr;
      logic start_valid;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [2:0] cmd;
      logic [15:0] addr;
      logic [7:0] data;
      logic fail;
      logic crc_done;
      logic [63:0][7:0] page;
      logic [63:0] mask;
      logic [5:0] idx;
      logic [31:0] timer;
      logic [31:0] crc;
      logic [15:0] crc_end;
      logic [15:0] faddr;
      logic [7:0] fwdata;
      logic fwe;
      logic fprog;
      logic ferase;
      logic [1:0] esize;
      logic [7:0] tr_data;
      logic tr_valid;
      logic tr_refused;
      logic [7:0] icp_hdr;
      logic [7:0] icp_in;
      logic [7:0] icp_out;
      logic [4:0] icp_cnt;
      logic sclk_prev;
   } fba_top_state_t;

endpackage

/* File: fba_sync2.sv */
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module fba_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,          // Clock.
   input wire logic rstn_i,         // Asynchronous reset, active low.
   input wire logic [W-1:0] d_i,    // Asynchronous inputs.
   output logic [W-1:0] q_o         // Synchronised outputs.
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fba_sync_state_t;

   fba_sync_state_t s_reg;
   fba_sync_state_t s_next;

   initial begin
      if (W < 1) begin
         $error("fba_sync2 needs at least one bit");
      end
   end

   always_comb begin
      s_next = s_reg;
      s_next.s1 = d_i;
      s_next.s2 = s_reg.s1;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q_o = s_reg.s2;
endmodule

/* File: fba_crc_step.sv */
// One byte step of the reflected 32-bit CRC.
`timescale 1ns/1ps
`include "fba_defines.svh"
module fba_crc_step (
   input wire logic [31:0] crc_i,   // CRC before the byte.
   input wire logic [7:0] data_i,   // Byte folded in.
   output logic [31:0] crc_o        // CRC after the byte.
);
   always_comb begin
      logic [31:0] c;
      c = crc_i ^ {24'h00_0000, data_i};
      for (int b = 0; b < 8; b++) begin
         c = c[0] ? ((c >> 1) ^ `FBA_CRC_POLY) : (c >> 1);
      end
      crc_o = c;
   end
endmodule

/* File: fba_flash_model.sv */
// Behavioural flash array that answers the block's array pins.
`timescale 1ns/1ps
module fba_flash_model (
   input wire logic clk_i,          // Clock.
   input wire logic [15:0] addr_i,  // Array address.
   input wire logic [7:0] wdata_i,  // Byte to program.
   input wire logic we_i,           // Byte strobe.
   input wire logic erase_i,        // Erase level.
   input wire logic [1:0] esize_i,  // Erase extent.
   output logic [7:0] rdata_o       // Read data.
);
   logic [7:0] mem [0:8191];
   logic erase_reg = 1'b0;
   int sh;
   // ==================================================================
   // Array behaviour
   initial for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
   assign rdata_o = mem[addr_i[12:0]];
   always @(posedge clk_i) begin
      erase_reg <= erase_i;
      sh = (esize_i == 2'h0) ? 0 : (esize_i == 2'h1) ? 6 : 10;
      if (we_i) mem[addr_i[12:0]] <= mem[addr_i[12:0]] & wdata_i;
      if (erase_i && !erase_reg) begin
         for (int i = 0; i < 8192; i++) if ((i >> sh) == (addr_i[12:0] >> sh)) mem[i] <= 8'hFF;
      end
   end
endmodule

/* File: fba_top_chk.sv */
// Assertion checker for the flash boot and program access block.
`timescale 1ns/1ps
module fba_top_chk #(
   parameter int NUM_SECTORS = 8,
   parameter int OP_CYCLES = 100
) (
   input wire logic clk_i, // Clock.
   input wire logic rstn_i, // Reset, active low.
   input wire logic [7:0] boot_status_i, // Boot status.
   input wire logic isp_force_i, // Loader force.
   input wire logic [NUM_SECTORS*8-1:0] sector_sec_i, // Security bytes.
   input wire logic brownout_detector_i, // Supply low.
   input wire logic [15:0] start_addr_o, // Start address.
   input wire logic start_valid_o, // Start settled.
   input wire logic [15:0] loader_base_o, // Loader base.
   input wire logic [7:0] cfg_one_o, // Config one.
   input wire logic [7:0] cfg_two_o, // Config two.
   input wire logic tr_req_i, // Read request.
   input wire logic [15:0] tr_addr_i, // Read address.
   input wire logic tr_ready_o, // Read ready.
   input wire logic tr_valid_o, // Read valid.
   input wire logic tr_refused_o, // Read refused.
   input wire logic flash_prog_o, // Program level.
   input wire logic flash_erase_o // Erase level.
);
   logic sec_hit;
   logic in_code;
   logic take;
   logic [31:0] hv_cnt_reg;
   assign sec_hit = sector_sec_i[{tr_addr_i[12:10], 3'h0}];
   assign in_code = tr_addr_i < 16'(NUM_SECTORS * 1024);
   assign take = tr_req_i && tr_ready_o;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) hv_cnt_reg <= 32'h0000_0000;
      else hv_cnt_reg <= (flash_prog_o || flash_erase_o) ? hv_cnt_reg + 32'h0000_0001 : 32'h0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ==================================================================
   // Assertions
   start_hold_a: assert property (start_valid_o && $past(start_valid_o) |-> $stable(start_addr_o))
      else $error("start address moved");
   low_byte_a: assert property (start_valid_o |-> start_addr_o[7:0] == 8'h00)
      else $error("start low byte not zero");
   zero_start_a: assert property ($rose(start_valid_o) && boot_status_i == 8'h00 && !isp_force_i
      |-> start_addr_o == 16'h0000) else $error("start not zero");
   cfg_fixed_a: assert property ($past(start_valid_o) |-> $stable(cfg_one_o) && $stable(cfg_two_o))
      else $error("config changed");
   refuse_sec_a: assert property (take && in_code && sec_hit |=> tr_refused_o && !tr_valid_o)
      else $error("secured read not refused");
   read_ok_a: assert property (take && in_code && !sec_hit |=> !tr_refused_o ##1 tr_valid_o)
      else $error("open read not answered");
   range_refuse_a: assert property (take && !in_code |=> tr_refused_o)
      else $error("out of range read not refused");
   brown_block_a: assert property (brownout_detector_i [*5] |-> !flash_prog_o && !flash_erase_o)
      else $error("high voltage during low supply");
   hv_limit_a: assert property (hv_cnt_reg <= OP_CYCLES)
      else $error("operation too long");
   loader_base_a: assert property (loader_base_o == 16'(NUM_SECTORS * 1024 - 512))
      else $error("loader base wrong");
   cover property ($rose(tr_refused_o));
   cover property ($rose(flash_erase_o));
   cover property ($rose(flash_prog_o));
endmodule
bind fba_top fba_top_chk #(.NUM_SECTORS(NUM_SECTORS), .OP_CYCLES(OP_CYCLES)) u_chk (.*);

/* File: fba_top_tb.sv */
// Self-checking testbench for the flash boot and program access block.
`timescale 1ns/1ps
`include "fba_defines.svh"
module fba_top_tb;
   logic clk_i = 1'b0, rstn_i = 1'b0, isp_force_i = 1'b0, brownout_detector_i = 1'b0;
   logic tr_req_i = 1'b0, iap_wr_i = 1'b0, icp_mode_i = 1'b0, icp_sclk_i = 1'b0;
   logic icp_sdata_i = 1'b0;
   logic [1:0] iap_sel_i = 2'h0;
   logic [7:0] boot_status_i = 8'h00, boot_vector_i = 8'h00, iap_wdata_i = 8'h00;
   logic [7:0] user_config_byte_one_i = 8'h00, user_config_byte_two_i = 8'h00;
   logic [15:0] tr_addr_i = 16'h0000;
   logic [63:0] sector_sec_i = 64'h0000_0000_0000_0000;
   logic [15:0] start_addr_o, loader_base_o, flash_addr_o;
   logic [7:0] cfg_one_o, cfg_two_o, tr_data_o, iap_rdata_o, flash_rdata_i, flash_wdata_o;
   logic [31:0] crc_o;
   logic [1:0] flash_esize_o;
   logic start_valid_o, tr_ready_o, tr_valid_o, tr_refused_o, icp_sdata_o, icp_sdata_oe_o;
   logic flash_we_o, flash_prog_o, flash_erase_o;
   int bad_count = 0;
   int compares = 0;
   fba_top #(.NUM_SECTORS(8), .OP_CYCLES(100)) DUT (.*);
   fba_flash_model u_flash (.clk_i, .addr_i(flash_addr_o), .wdata_i(flash_wdata_o),
      .we_i(flash_we_o), .erase_i(flash_erase_o), .esize_i(flash_esize_o), .rdata_o(flash_rdata_i));
   always #4 clk_i = ~clk_i;
   // ==================================================================
   // Shared tasks
   task automatic end_sim();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [1:0] sel, logic [7:0] d);
      @(posedge clk_i);
      iap_wr_i <= 1'b1;
      iap_sel_i <= sel;
      iap_wdata_i <= d;
      @(posedge clk_i);
      iap_wr_i <= 1'b0;
      iap_sel_i <= `FBA_REG_CTRL;
      @(posedge clk_i);
   endtask
   task automatic op(logic [15:0] a, logic [7:0] d, logic [2:0] c);
      wr(`FBA_REG_ADDRH, a[15:8]);
      wr(`FBA_REG_ADDRL, a[7:0]);
      wr(`FBA_REG_DATA, d);
      wr(`FBA_REG_CTRL, {5'h00, c});
      for (int n = 0; n < 9000 && iap_rdata_o[7] !== 1'b0; n++) @(negedge clk_i);
      chk("busy", iap_rdata_o[7], 1'b0);
      @(posedge clk_i);
   endtask
   // programmer frame, MSB first, read bits sampled before each rise.
   task automatic in_circuit_programming(logic [15:0] f, output logic [7:0] q);
      icp_mode_i <= 1'b1;
      for (int b = 15; b >= 0; b--) begin
         icp_sdata_i <= f[b];
         repeat (4) @(posedge clk_i);
         if (b < 8) q[b] = icp_sdata_o;
         icp_sclk_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         icp_sclk_i <= 1'b0;
      end
      icp_mode_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic rd(logic [15:0] a, logic ok, logic [7:0] d);
      @(posedge clk_i);
      tr_req_i <= 1'b1;
      tr_addr_i <= a;
      @(negedge clk_i);
      for (int n = 0; n < 100 && tr_ready_o !== 1'b1; n++) @(negedge clk_i);
      @(posedge clk_i);
      tr_req_i <= 1'b0;
      @(negedge clk_i);
      chk("refused", tr_refused_o, !ok);
      if (ok) begin
         @(negedge clk_i);
         chk("valid", tr_valid_o, 1'b1);
         chk("read data", tr_data_o, d);
      end
      @(posedge clk_i);
   endtask
   task automatic boot(logic [7:0] st, logic [7:0] vec, logic frc, logic [15:0] exp);
      @(posedge clk_i);
      rstn_i <= 1'b0;
      boot_status_i <= st;
      boot_vector_i <= vec;
      isp_force_i <= frc;
      user_config_byte_one_i <= 8'hA5;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int n = 0; n < 50 && start_valid_o !== 1'b1; n++) @(negedge clk_i);
      chk("start address", start_addr_o, exp);
      @(posedge clk_i);
   endtask
   function automatic logic [31:0] crc_of(int n);
      logic [31:0] c;
      c = `FBA_CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ ((i == 16'h0106) ? 32'h0000_00A7 : 32'h0000_00FF);
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `FBA_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // ==================================================================
   // Scenarios
   task automatic t_boot();
      boot(8'h00, 8'h12, 1'b0, 16'h0000);
      boot(8'h01, 8'h12, 1'b0, 16'h1200);
      boot(8'h00, 8'h34, 1'b1, 16'h3400);
      boot(8'h01, 8'hFF, 1'b0, 16'h1F00);
      user_config_byte_one_i <= 8'h5A;
      boot_status_i <= 8'h00;
      repeat (6) @(posedge clk_i);
      chk("config one", cfg_one_o, 8'hA5);
      chk("start held", start_addr_o, 16'h1F00);
      $display("test boot done");
   endtask
   task automatic t_prog();
      op(16'h0105, 8'h3C, `FBA_CMD_LOAD);
      op(16'h0106, 8'hA7, `FBA_CMD_LOAD);
      op(16'h0100, 8'h00, `FBA_CMD_PROG);
      rd(16'h0105, 1'b1, 8'h3C);
      rd(16'h0107, 1'b1, 8'hFF);
      op(16'h0105, 8'h00, `FBA_CMD_ERASE_BYTE);
      rd(16'h0105, 1'b1, 8'hFF);
      rd(16'h0106, 1'b1, 8'hA7);
      op(16'h0000, 8'h00, `FBA_CMD_CRC_SECTOR);
      chk("crc done", iap_rdata_o[5], 1'b1);
      chk("crc sector", crc_o, crc_of(1024));
      op(16'h0000, 8'h00, `FBA_CMD_CRC_ALL);
      chk("crc all", crc_o, crc_of(8192));
      op(16'h0C10, 8'h11, `FBA_CMD_LOAD);
      op(16'h0C00, 8'h00, `FBA_CMD_PROG);
      op(16'h0C00, 8'h00, `FBA_CMD_ERASE_PAGE);
      rd(16'h0C10, 1'b1, 8'hFF);
      op(16'h0000, 8'h00, `FBA_CMD_ERASE_SECTOR);
      rd(16'h0106, 1'b1, 8'hFF);
      $display("test program done");
   endtask
   task automatic t_secure();
      sector_sec_i <= 64'h0000_0000_0000_0100;
      rd(16'h07FF, 1'b0, 8'h00);
      rd(16'h0800, 1'b1, 8'hFF);
      rd(16'h2000, 1'b0, 8'h00);
      sector_sec_i <= 64'h0000_0000_0000_0000;
      $display("test secure done");
   endtask
   task automatic t_brown();
      op(16'h0200, 8'h55, `FBA_CMD_LOAD);
      op(16'h0200, 8'h00, `FBA_CMD_PROG);
      brownout_detector_i <= 1'b1;
      op(16'h0200, 8'h00, `FBA_CMD_ERASE_BYTE);
      chk("fail flag", iap_rdata_o[6], 1'b1);
      brownout_detector_i <= 1'b0;
      rd(16'h0200, 1'b1, 8'h55);
      wr(`FBA_REG_CTRL, 8'h40);
      chk("fail clear", iap_rdata_o[6], 1'b0);
      $display("test brownout done");
   endtask
   task automatic t_icp();
      logic [7:0] q;
      in_circuit_programming(16'h825C, q);
      in_circuit_programming(16'h0200, q);
      chk("icp read", q, 8'h5C);
      $display("test icp done");
   endtask
   initial begin
      #160000;
      bad_count++;
      end_sim();
   end
   initial begin
      t_boot();
      t_prog();
      t_secure();
      t_brown();
      t_icp();
      end_sim();
   end
endmodule
